// >>> logic/ipfs_cfg.svh
// offsets, field positions, codes and reset values of the pin function select
`ifndef IPFS_CFG_SVH
`define IPFS_CFG_SVH

// register offsets
`define IPFS_ADDR_POLARITY   8'h36
`define IPFS_ADDR_TX_CFG     8'h3d
`define IPFS_ADDR_RX_CFG     8'h3e
`define IPFS_ADDR_SERVO_CFG  8'h3f
`define IPFS_ADDR_KILL_MAP   8'h5d

// reset values
`define IPFS_RST_CFG         8'h00
`define IPFS_RST_POLARITY    8'h00

// fields of a pin configuration byte
`define IPFS_FUNC_LSB        0
`define IPFS_FUNC_MSB        3
`define IPFS_ANALOG_BIT      6
`define IPFS_PULLUP_BIT      7

// function codes
`define IPFS_FN_DEFAULT      4'h0
`define IPFS_FN_USER_IO      4'h1
`define IPFS_FN_USER_INPUT   4'h2
`define IPFS_FN_SERIAL       4'h4
`define IPFS_FN_PULSE        4'h5
`define IPFS_FN_ENCODER      4'h6
`define IPFS_FN_KILL         4'h7

// bit of each pin in the polarity and kill switch map bytes
`define IPFS_BIT_TX          2
`define IPFS_BIT_RX          3
`define IPFS_BIT_SERVO       4

`endif

// >>> logic/ipfs_pkg.sv
// types shared by the pin function select
package ipfs_pkg;

  // role a pin takes after decoding
  typedef enum logic [2:0] {
    IPFS_ROLE_USER_IO,
    IPFS_ROLE_USER_INPUT,
    IPFS_ROLE_SERIAL_TX,
    IPFS_ROLE_SERIAL_RX,
    IPFS_ROLE_ENCODER,
    IPFS_ROLE_KILL,
    IPFS_ROLE_PULSE_IN
  } ipfs_role_type;

  // which pin a decode is for
  typedef enum logic [1:0] {
    IPFS_PIN_TX,
    IPFS_PIN_RX,
    IPFS_PIN_SERVO
  } ipfs_pin_type;

endpackage

// >>> logic/ipfs_pin_select.sv
// function select for the transmit, receive and servo pulse input pins
//
// Summary of operation
// R01: transmit byte low nibble selects pin function
// R02: receive byte low nibble selects pin function
// R03: software keeps reserved bits 4 and 5 zero
// R04: bit 6 enables analog on transmit, receive
// R05: bit 7 ignored, transmit/receive always pulled up
// R06: servo pulse bit 6 ignored, no analog
// R07: servo pulse bit 7 ignored, always pulled down
// R08: function zero ignores all other options
// R09: default transmit: encoder mode encoder, else serial
// R10: default receive: encoder mode encoder, else serial
// R11: default servo pulse pin measures pulse widths
// R12: configuration bytes reset to zero, default function
// R13: polarity byte bits 2-4, one means active high
// R14: kill map bits 2-4 follow kill configuration
// R15: unlisted function codes behave as default
`timescale 1ns/100ps
`include "ipfs_cfg.svh"

module ipfs_pin_select
  import ipfs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // control mode
  input  wire logic              i_encoder_mode,
  // pin levels, synchronous to i_clk
  input  wire logic              i_tx_pin,
  input  wire logic              i_rx_pin,
  input  wire logic              i_servo_pulse_pin,
  // transmit pin setup
  output ipfs_role_type          o_tx_role,
  output logic                   o_tx_analog_en,
  output logic                   o_tx_pullup,
  // receive pin setup
  output ipfs_role_type          o_rx_role,
  output logic                   o_rx_analog_en,
  output logic                   o_rx_pullup,
  // servo pulse pin setup
  output ipfs_role_type          o_servo_pulse_role,
  output logic                   o_servo_pulse_pulldown,
  // switch results
  output logic                   o_tx_switch_active,
  output logic                   o_rx_switch_active,
  output logic                   o_servo_pulse_switch_active,
  output logic                   o_kill
);

  // complete state of the block
  typedef struct packed {
    logic [7:0]    tx_cfg;
    logic [7:0]    rx_cfg;
    logic [7:0]    servo_cfg;
    logic [7:0]    polarity;
    logic [7:0]    kill_map;
    logic [DATA_W-1:0] rdata;
    ipfs_role_type tx_role;
    ipfs_role_type rx_role;
    ipfs_role_type servo_role;
    logic          tx_analog;
    logic          rx_analog;
    logic          tx_sw;
    logic          rx_sw;
    logic          servo_sw;
    logic          kill;
  } ipfs_state_type;

  ipfs_state_type state;
  ipfs_state_type next_state;

  // decode a function nibble into a role for one pin
  function automatic ipfs_role_type pin_role(
    input logic [3:0]   code,
    input ipfs_pin_type pin,
    input logic         enc_mode
  );
    ipfs_role_type dflt;
    ipfs_role_type role;
    logic          listed;
    // built-in role when the nibble selects default
    unique case (pin)
      IPFS_PIN_TX: begin
        dflt = enc_mode ? IPFS_ROLE_ENCODER       // R09
                        : IPFS_ROLE_SERIAL_TX;    // R09
      end
      IPFS_PIN_RX: begin
        dflt = enc_mode ? IPFS_ROLE_ENCODER       // R10
                        : IPFS_ROLE_SERIAL_RX;    // R10
      end
      IPFS_PIN_SERVO: begin
        dflt = IPFS_ROLE_PULSE_IN;                // R11
      end
      default: begin
        dflt = IPFS_ROLE_USER_INPUT;
      end
    endcase
    role   = dflt;
    listed = 1'b0;
    unique case (code)
      `IPFS_FN_USER_IO: begin
        // servo pulse pin has no output path
        listed = (pin != IPFS_PIN_SERVO);         // R01 R02
        role   = IPFS_ROLE_USER_IO;
      end
      `IPFS_FN_USER_INPUT: begin
        listed = 1'b1;
        role   = IPFS_ROLE_USER_INPUT;
      end
      `IPFS_FN_SERIAL: begin
        listed = (pin != IPFS_PIN_SERVO);
        role   = (pin == IPFS_PIN_TX) ? IPFS_ROLE_SERIAL_TX  // R01
                                      : IPFS_ROLE_SERIAL_RX; // R02
      end
      `IPFS_FN_PULSE: begin
        listed = (pin == IPFS_PIN_SERVO);
        role   = IPFS_ROLE_PULSE_IN;
      end
      `IPFS_FN_ENCODER: begin
        listed = (pin != IPFS_PIN_SERVO);         // R01 R02
        role   = IPFS_ROLE_ENCODER;
      end
      `IPFS_FN_KILL: begin
        listed = 1'b1;
        role   = IPFS_ROLE_KILL;
      end
      default: begin
        // code 0 and every code without a branch of its own
        listed = 1'b0;                            // R08 R15
        role   = dflt;
      end
    endcase
    // an unlisted code keeps the pin in its built-in role
    if (!listed) begin
      role = dflt;                                // R15
    end
    return role;
  endfunction

  // analog readings only under an explicit, listed function
  function automatic logic pin_analog(
    input logic [7:0] cfg,
    input logic       listed_fn
  );
    // default function ignores bit 6 along with everything else
    return listed_fn & cfg[`IPFS_ANALOG_BIT];     // R04 R08
  endfunction

  // true when the nibble names a function listed for the pin
  function automatic logic fn_listed(
    input logic [3:0]   code,
    input ipfs_pin_type pin
  );
    logic ok;
    unique case (code)
      `IPFS_FN_USER_INPUT,
      `IPFS_FN_KILL: begin
        ok = 1'b1;
      end
      `IPFS_FN_USER_IO,
      `IPFS_FN_SERIAL,
      `IPFS_FN_ENCODER: begin
        ok = (pin != IPFS_PIN_SERVO);
      end
      `IPFS_FN_PULSE: begin
        ok = (pin == IPFS_PIN_SERVO);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // pin level turned into switch activity by its polarity bit
  function automatic logic sw_level(
    input logic level,
    input logic active_high
  );
    // zero polarity means a low level is the active switch
    return active_high ? level : ~level;          // R13
  endfunction

  always_comb begin
    logic [3:0] tx_fn;
    logic [3:0] rx_fn;
    logic [3:0] servo_fn;
    logic       tx_kill;
    logic       rx_kill;
    logic       servo_kill;
    next_state = state;
    tx_fn      = state.tx_cfg[`IPFS_FUNC_MSB:`IPFS_FUNC_LSB];
    rx_fn      = state.rx_cfg[`IPFS_FUNC_MSB:`IPFS_FUNC_LSB];
    servo_fn   = state.servo_cfg[`IPFS_FUNC_MSB:`IPFS_FUNC_LSB];
    tx_kill    = 1'b0;
    rx_kill    = 1'b0;
    servo_kill = 1'b0;

    // register writes; whole configuration bytes are kept, ignored bits included,
    // so software reads them back exactly as it wrote them
    if (i_wr) begin
      unique case (i_addr)
        `IPFS_ADDR_TX_CFG: begin
          next_state.tx_cfg = i_wdata[7:0];       // R01
        end
        `IPFS_ADDR_RX_CFG: begin
          next_state.rx_cfg = i_wdata[7:0];       // R02
        end
        `IPFS_ADDR_SERVO_CFG: begin
          next_state.servo_cfg = i_wdata[7:0];
        end
        `IPFS_ADDR_POLARITY: begin
          // only the three bits owned by these pins are kept
          next_state.polarity = 8'h00;
          next_state.polarity[`IPFS_BIT_TX] =
            i_wdata[`IPFS_BIT_TX];                // R13
          next_state.polarity[`IPFS_BIT_RX] =
            i_wdata[`IPFS_BIT_RX];                // R13
          next_state.polarity[`IPFS_BIT_SERVO] =
            i_wdata[`IPFS_BIT_SERVO];             // R13
        end
        default: begin
          // kill map is derived, writes to it and unmapped
          // addresses are dropped
        end
      endcase
    end

    // read data stands in the cycle after the strobe only
    next_state.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        `IPFS_ADDR_TX_CFG: begin
          next_state.rdata[7:0] = state.tx_cfg;
        end
        `IPFS_ADDR_RX_CFG: begin
          next_state.rdata[7:0] = state.rx_cfg;
        end
        `IPFS_ADDR_SERVO_CFG: begin
          next_state.rdata[7:0] = state.servo_cfg;
        end
        `IPFS_ADDR_POLARITY: begin
          next_state.rdata[7:0] = state.polarity;
        end
        `IPFS_ADDR_KILL_MAP: begin
          next_state.rdata[7:0] = state.kill_map;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end

    // role decode from the stored bytes and the control mode
    next_state.tx_role =
      pin_role(tx_fn, IPFS_PIN_TX, i_encoder_mode);        // R01
    next_state.rx_role =
      pin_role(rx_fn, IPFS_PIN_RX, i_encoder_mode);        // R02
    next_state.servo_role =
      pin_role(servo_fn, IPFS_PIN_SERVO, i_encoder_mode);  // R11

    // analog enables; servo pulse pin has none at all
    next_state.tx_analog =
      pin_analog(state.tx_cfg, fn_listed(tx_fn, IPFS_PIN_TX));  // R04
    next_state.rx_analog =
      pin_analog(state.rx_cfg, fn_listed(rx_fn, IPFS_PIN_RX));  // R04

    // kill switch membership follows the decoded role
    tx_kill    = (next_state.tx_role == IPFS_ROLE_KILL);
    rx_kill    = (next_state.rx_role == IPFS_ROLE_KILL);
    servo_kill = (next_state.servo_role == IPFS_ROLE_KILL);
    next_state.kill_map                  = 8'h00;
    next_state.kill_map[`IPFS_BIT_TX]    = tx_kill;        // R14
    next_state.kill_map[`IPFS_BIT_RX]    = rx_kill;        // R14
    next_state.kill_map[`IPFS_BIT_SERVO] = servo_kill;     // R14

    // switch activity uses the polarity of each pin
    next_state.tx_sw = sw_level(i_tx_pin,
      state.polarity[`IPFS_BIT_TX]);                       // R13
    next_state.rx_sw = sw_level(i_rx_pin,
      state.polarity[`IPFS_BIT_RX]);                       // R13
    next_state.servo_sw = sw_level(i_servo_pulse_pin,
      state.polarity[`IPFS_BIT_SERVO]);                    // R13

    // kill only from pins that are kill switches this cycle
    next_state.kill =
      (state.kill_map[`IPFS_BIT_TX]    & next_state.tx_sw) |
      (state.kill_map[`IPFS_BIT_RX]    & next_state.rx_sw) |
      (state.kill_map[`IPFS_BIT_SERVO] & next_state.servo_sw);  // R14
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state.tx_cfg     <= `IPFS_RST_CFG;          // R12
      state.rx_cfg     <= `IPFS_RST_CFG;          // R12
      state.servo_cfg  <= `IPFS_RST_CFG;          // R12
      state.polarity   <= `IPFS_RST_POLARITY;
      state.kill_map   <= 8'h00;
      state.rdata      <= '0;
      // roles match what a zero byte selects outside encoder mode
      state.tx_role    <= IPFS_ROLE_SERIAL_TX;
      state.rx_role    <= IPFS_ROLE_SERIAL_RX;
      state.servo_role <= IPFS_ROLE_PULSE_IN;
      state.tx_analog  <= 1'b0;
      state.rx_analog  <= 1'b0;
      state.tx_sw      <= 1'b0;
      state.rx_sw      <= 1'b0;
      state.servo_sw   <= 1'b0;
      state.kill       <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign o_rdata                     = state.rdata;
  assign o_tx_role                   = state.tx_role;
  assign o_tx_analog_en              = state.tx_analog;
  // bit 7 never reaches the pads: fixed pulls on every pin
  assign o_tx_pullup                 = 1'b1;      // R05
  assign o_rx_role                   = state.rx_role;
  assign o_rx_analog_en              = state.rx_analog;
  assign o_rx_pullup                 = 1'b1;      // R05
  assign o_servo_pulse_role          = state.servo_role;
  // bit 6 of the servo pulse byte drives nothing
  assign o_servo_pulse_pulldown      = 1'b1;      // R06 R07
  assign o_tx_switch_active          = state.tx_sw;
  assign o_rx_switch_active          = state.rx_sw;
  assign o_servo_pulse_switch_active = state.servo_sw;
  assign o_kill                      = state.kill;

endmodule

// >>> test/ipfs_pin_select_props.sv
// assertion checker for the pin function select
`timescale 1ns/100ps
`include "ipfs_cfg.svh"

module ipfs_pin_select_props
  import ipfs_pkg::*;
(
  // clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  // register port, mode and transmit pin level
  input wire logic [7:0]    i_addr,
  input wire logic [7:0]    i_wdata,
  input wire logic          i_wr,
  input wire logic          i_rd,
  input wire logic [7:0]    o_rdata,
  input wire logic          i_encoder_mode,
  input wire logic          i_tx_pin,
  // pin setup and switch results
  input wire ipfs_role_type o_tx_role,
  input wire ipfs_role_type o_rx_role,
  input wire ipfs_role_type o_servo_pulse_role,
  input wire logic          o_rx_analog_en,
  input wire logic          o_tx_pullup,
  input wire logic          o_rx_pullup,
  input wire logic          o_servo_pulse_pulldown,
  input wire logic          o_tx_switch_active,
  input wire logic          o_rx_switch_active,
  input wire logic          o_servo_pulse_switch_active,
  input wire logic          o_kill
);
  logic [7:0] pol;

  // shadow of the polarity byte, only so switch levels can be judged
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pol <= 8'h00;
    end else if (i_wr && i_addr == `IPFS_ADDR_POLARITY) begin
      pol <= i_wdata;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  pull_fixed_a: assert property (
    o_tx_pullup && o_rx_pullup && o_servo_pulse_pulldown)
    else $error("pull resistors not fixed");
  readback_a: assert property (
    (i_wr && i_addr == `IPFS_ADDR_TX_CFG) ##1
    (i_rd && i_addr == `IPFS_ADDR_TX_CFG) |=> o_rdata == $past(i_wdata, 2))
    else $error("transmit byte readback wrong");
  tx_default_a: assert property (
    (i_wr && i_addr == `IPFS_ADDR_TX_CFG && i_wdata[3:0] == 4'h0) ##1
    !(i_wr && i_addr == `IPFS_ADDR_TX_CFG) |=> o_tx_role ==
    ($past(i_encoder_mode) ? IPFS_ROLE_ENCODER : IPFS_ROLE_SERIAL_TX))
    else $error("transmit default role wrong");
  rx_default_a: assert property (
    (i_wr && i_addr == `IPFS_ADDR_RX_CFG && i_wdata[3:0] == 4'h0) ##1
    !(i_wr && i_addr == `IPFS_ADDR_RX_CFG) |=> o_rx_role ==
    ($past(i_encoder_mode) ? IPFS_ROLE_ENCODER : IPFS_ROLE_SERIAL_RX))
    else $error("receive default role wrong");
  rx_analog_a: assert property (
    (i_wr && i_addr == `IPFS_ADDR_RX_CFG && i_wdata[6:0] == 7'h41) ##1
    !(i_wr && i_addr == `IPFS_ADDR_RX_CFG) |=> o_rx_analog_en)
    else $error("receive analog not enabled");
  servo_pulse_a: assert property (
    (i_wr && i_addr == `IPFS_ADDR_SERVO_CFG && i_wdata[3:0] == 4'h0) ##1
    !(i_wr && i_addr == `IPFS_ADDR_SERVO_CFG) |=>
    o_servo_pulse_role == IPFS_ROLE_PULSE_IN)
    else $error("servo pulse default role wrong");
  tx_switch_a: assert property (
    $past(i_rst_n) |->
    o_tx_switch_active == ($past(i_tx_pin) ~^ $past(pol[2])))
    else $error("transmit switch level wrong");
  kill_cause_a: assert property (
    o_kill |-> (o_tx_switch_active || o_rx_switch_active ||
    o_servo_pulse_switch_active))
    else $error("kill without active switch");
endmodule

bind ipfs_pin_select ipfs_pin_select_props props_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_encoder_mode(i_encoder_mode), .i_tx_pin(i_tx_pin),
  .o_tx_role(o_tx_role), .o_rx_role(o_rx_role),
  .o_servo_pulse_role(o_servo_pulse_role), .o_rx_analog_en(o_rx_analog_en),
  .o_tx_pullup(o_tx_pullup), .o_rx_pullup(o_rx_pullup),
  .o_servo_pulse_pulldown(o_servo_pulse_pulldown),
  .o_tx_switch_active(o_tx_switch_active),
  .o_rx_switch_active(o_rx_switch_active),
  .o_servo_pulse_switch_active(o_servo_pulse_switch_active),
  .o_kill(o_kill));

// >>> test/ipfs_pin_select_tb.sv
// self-checking bench for the pin function select
`timescale 1ns/100ps
`include "ipfs_cfg.svh"

module ipfs_pin_select_tb
  import ipfs_pkg::*;
;
  logic          i_clk, i_rst_n, i_wr, i_rd, i_encoder_mode;
  logic          i_tx_pin, i_rx_pin, i_servo_pulse_pin;
  logic [7:0]    i_addr, i_wdata, o_rdata, pol, v;
  logic [7:0]    cfg [3];
  logic [31:0]   r;
  ipfs_role_type o_tx_role, o_rx_role, o_servo_pulse_role;
  logic          o_tx_analog_en, o_rx_analog_en, o_tx_pullup, o_rx_pullup;
  logic          o_servo_pulse_pulldown, o_tx_switch_active, o_kill;
  logic          o_rx_switch_active, o_servo_pulse_switch_active;
  int            num_errors, check_count, seed, cyc;

  ipfs_pin_select dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_encoder_mode(i_encoder_mode), .i_tx_pin(i_tx_pin),
    .i_rx_pin(i_rx_pin), .i_servo_pulse_pin(i_servo_pulse_pin),
    .o_tx_role(o_tx_role), .o_tx_analog_en(o_tx_analog_en),
    .o_tx_pullup(o_tx_pullup), .o_rx_role(o_rx_role),
    .o_rx_analog_en(o_rx_analog_en), .o_rx_pullup(o_rx_pullup),
    .o_servo_pulse_role(o_servo_pulse_role),
    .o_servo_pulse_pulldown(o_servo_pulse_pulldown),
    .o_tx_switch_active(o_tx_switch_active),
    .o_rx_switch_active(o_rx_switch_active),
    .o_servo_pulse_switch_active(o_servo_pulse_switch_active),
    .o_kill(o_kill));

  // unlisted codes fall back to the default role, so never undefined
  function automatic logic [2:0] role_of(int p, logic [3:0] c, logic e);
    case (c)
      `IPFS_FN_KILL: return IPFS_ROLE_KILL;
      `IPFS_FN_USER_INPUT: return IPFS_ROLE_USER_INPUT;
      `IPFS_FN_USER_IO: if (p != 2) return IPFS_ROLE_USER_IO;
      `IPFS_FN_ENCODER: if (p != 2) return IPFS_ROLE_ENCODER;
      `IPFS_FN_SERIAL: if (p != 2) return p ? IPFS_ROLE_SERIAL_RX
                                            : IPFS_ROLE_SERIAL_TX;
      default: ;
    endcase
    if (p == 2) return IPFS_ROLE_PULSE_IN;
    if (e) return IPFS_ROLE_ENCODER;
    return p ? IPFS_ROLE_SERIAL_RX : IPFS_ROLE_SERIAL_TX;
  endfunction

  function automatic logic ana(logic [7:0] c);
    return c[6] && (c[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7});
  endfunction

  function automatic logic [7:0] kill_exp();
    return {3'h0, cfg[2][3:0] == 4'h7, cfg[1][3:0] == 4'h7,
            cfg[0][3:0] == 4'h7, 2'h0};
  endfunction

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_clk);
  endtask

  task automatic idle(int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask

  task automatic set_cfg(int p, logic [7:0] d);
    wr(8'(`IPFS_ADDR_TX_CFG + p), d);
    cfg[p] = d;
  endtask

  task automatic chk_roles();
    chk(8'(o_tx_role), 8'(role_of(0, cfg[0][3:0], i_encoder_mode)));
    chk(8'(o_rx_role), 8'(role_of(1, cfg[1][3:0], i_encoder_mode)));
    chk(8'(o_servo_pulse_role), 8'(role_of(2, cfg[2][3:0], 1'b0)));
    chk(8'(o_tx_analog_en), 8'(ana(cfg[0])));
    chk(8'(o_rx_analog_en), 8'(ana(cfg[1])));
    chk(8'(o_tx_pullup & o_rx_pullup), 8'h01);
    chk(8'(o_servo_pulse_pulldown), 8'h01);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // budget well above the roughly 750 cycles the tests take
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    seed = 16;
    {i_rst_n, i_wr, i_rd, i_encoder_mode, i_addr, i_wdata} = '0;
    {i_tx_pin, i_rx_pin, i_servo_pulse_pin} = 3'h7;
    cfg = '{default: 8'h00};
    pol = 8'h00;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 3; a++) rd_chk(8'(8'h3d + a), `IPFS_RST_CFG);
    chk_roles();
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 32; c++) begin
        v = {2'($random(seed)), 2'h0, 4'(c)};
        i_encoder_mode <= c[4];
        set_cfg(p, v);
        rd_chk(8'(8'h3d + p), v);
        chk_roles();
        rd_chk(`IPFS_ADDR_KILL_MAP, kill_exp());
      end
    end
    $display("test function table done");
    for (int n = 0; n < 24; n++) begin
      r = $random(seed);
      {i_servo_pulse_pin, i_rx_pin, i_tx_pin} <= r[18:16];
      for (int p = 0; p < 3; p++) set_cfg(p, r[p] ? 8'h07 : 8'hc1);
      wr(`IPFS_ADDR_POLARITY, r[15:8]);
      pol = r[15:8] & 8'h1c;
      idle(4);
      rd_chk(`IPFS_ADDR_POLARITY, pol);
      v = {5'h0, r[18:16] ~^ pol[4:2]};
      chk(8'(o_tx_switch_active), 8'(v[0]));
      chk(8'(o_rx_switch_active), 8'(v[1]));
      chk(8'(o_servo_pulse_switch_active), 8'(v[2]));
      chk(8'(o_kill), 8'(|(v[2:0] & r[2:0])));
      chk_roles();
    end
    $display("test switches done");
    wr(`IPFS_ADDR_KILL_MAP, 8'hff);
    rd_chk(`IPFS_ADDR_KILL_MAP, kill_exp());
    wr(8'h40, 8'h5a);
    rd_chk(8'h40, 8'h00);
    wr(`IPFS_ADDR_POLARITY, 8'hff);
    rd_chk(`IPFS_ADDR_POLARITY, 8'h1c);
    $display("test refused writes done");
    i_rst_n <= 1'b0;
    idle(2);
    i_rst_n <= 1'b1;
    cfg = '{default: 8'h00};
    idle(2);
    for (int a = 0; a < 3; a++) rd_chk(8'(8'h3d + a), 8'h00);
    chk_roles();
    $display("test second reset done");
    end_of_test();
  end
endmodule
